// ---- rtc_ctl_pkg.sv ----
package rtc_ctl_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL   = 6'h00;
  localparam logic [5:0] IDX_RDREQ  = 6'h02;
  localparam logic [5:0] IDX_EVENT_OUTPUT_CONTROL = 6'h04;
  localparam logic [5:0] IDX_STATUS = 6'h0a;
  localparam logic [5:0] IDX_COUNT  = 6'h10;
  // counter_control fields
  localparam int CTRL_SRT  = 0;
  localparam int CTRL_EN   = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_HFS  = 6;
  localparam int CTRL_ZOM  = 7;
  localparam int CTRL_PSC  = 8;
  // read_sync_request fields
  localparam int RDREQ_TRIG = 15;
  localparam int RDREQ_CONT = 14;
  localparam logic [5:0] RDREQ_ADDR = 6'h10;
  // event_output_control fields
  localparam int EV_OVF = 15;
  localparam int EV_CMP = 8;
  // status field
  localparam int STATUS_BUSY = 7;
  // reset values
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] RDREQ_RESET  = 16'h0010;
  localparam logic [15:0] EVENT_OUTPUT_CONTROL_RESET = 16'h0000;
  // prescaler limit and synchronisation timing
  localparam logic [3:0] PSC_MAX   = 4'ha;
  localparam int         SYNC_NS   = 30;
  localparam int         CLK_PS    = 5000;
  localparam logic [2:0] SYNC_CYC  = 3'((SYNC_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;

  typedef enum logic [1:0] {
    MODE_WIDE = 2'b00,
    MODE_HALF = 2'b01,
    MODE_CAL  = 2'b10,
    MODE_RSV  = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_EN    = 2'b01,
    OP_RST   = 2'b10,
    OP_READ  = 2'b11
  } op_t;

  // events coming from the counting logic
  typedef struct packed {
    logic       overflow;
    logic       compare0;
    logic [7:0] periodic;
  } evt_t;
endpackage : rtc_ctl_pkg

// ---- rtc_ctl.sv ----
`timescale 1ns/1ps
module rtc_ctl (
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  input  wire logic               i_awvalid,
  output logic                    o_awready,
  input  wire logic [7:0]         i_awaddr,
  input  wire logic               i_wvalid,
  output logic                    o_wready,
  input  wire logic [31:0]        i_wdata,
  input  wire logic [3:0]         i_wstrb,
  output logic                    o_bvalid,
  input  wire logic               i_bready,
  output logic [1:0]              o_bresp,
  input  wire logic               i_arvalid,
  output logic                    o_arready,
  input  wire logic [7:0]         i_araddr,
  output logic                    o_rvalid,
  input  wire logic               i_rready,
  output logic [31:0]             o_rdata,
  output logic [1:0]              o_rresp,
  input  wire logic [31:0]        i_count_value,
  input  wire rtc_ctl_pkg::evt_t  i_events,
  output logic                    o_counter_tick,
  output logic                    o_counter_run,
  output rtc_ctl_pkg::mode_t      o_mode,
  output logic                    o_hour_format_select,
  output logic                    o_counter_zero,
  output logic                    o_count_load,
  output logic [31:0]             o_count_load_data,
  output rtc_ctl_pkg::evt_t       o_events
);

  typedef struct packed {
    logic               awv;
    logic [5:0]         aw_idx;
    logic               wv;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic [3:0]         psc;
    logic               zom;
    logic               hfs;
    rtc_ctl_pkg::mode_t mode;
    logic               en;
    logic               srt;
    logic               cont;
    logic               trig;
    logic               ev_ovf;
    logic               ev_cmp;
    logic [7:0]         ev_per;
    logic               run;
    logic               busy;
    rtc_ctl_pkg::op_t   op;
    logic               req;
    logic [2:0]         dly;
    logic [9:0]         div;
    logic               tick;
    logic [31:0]        copy;
    logic               zero;
    logic               load;
    logic [31:0]        load_data;
    rtc_ctl_pkg::evt_t  ev;
  } state_t;

  state_t s;
  state_t next_s;

  // merge written bytes into a 16-bit register image
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0]) r[7:0] = wd[7:0];
    if (st[1]) r[15:8] = wd[15:8];
    return r;
  endfunction : merge16

  logic [15:0] ctrl_img;
  logic [15:0] rdreq_img;
  logic [15:0] ev_img;
  logic [15:0] wr_img;
  logic [3:0]  psc_eff;
  logic [9:0]  div_mask;
  logic        commit;
  logic        stall;

  // register images as software sees them
  always_comb begin
    ctrl_img = rtc_ctl_pkg::CTRL_RESET;
    ctrl_img[rtc_ctl_pkg::CTRL_SRT] = s.srt;
    ctrl_img[rtc_ctl_pkg::CTRL_EN] = s.en;
    ctrl_img[rtc_ctl_pkg::CTRL_MODE +: 2] = s.mode;
    ctrl_img[rtc_ctl_pkg::CTRL_HFS] = s.hfs;
    ctrl_img[rtc_ctl_pkg::CTRL_ZOM] = s.zom;
    ctrl_img[rtc_ctl_pkg::CTRL_PSC +: 4] = s.psc;
    rdreq_img = rtc_ctl_pkg::RDREQ_RESET;
    rdreq_img[rtc_ctl_pkg::RDREQ_CONT] = s.cont;
    ev_img = rtc_ctl_pkg::EVENT_OUTPUT_CONTROL_RESET;
    ev_img[rtc_ctl_pkg::EV_OVF] = s.ev_ovf;
    ev_img[rtc_ctl_pkg::EV_CMP] = s.ev_cmp;
    ev_img[7:0] = s.ev_per;
  end

  // reserved codes above ten run as the slowest divider
  assign psc_eff  = (s.psc > rtc_ctl_pkg::PSC_MAX) ? rtc_ctl_pkg::PSC_MAX : s.psc;
  assign div_mask = 10'((11'h001 << psc_eff) - 11'h001);

  // a count write waits while a continuous read copy is in flight
  assign stall  = s.aw_idx == rtc_ctl_pkg::IDX_COUNT && s.cont
                  && s.op == rtc_ctl_pkg::OP_READ;
  assign commit = s.awv && s.wv && !s.bvalid && !stall;

  always_comb begin
    next_s = s;
    next_s.load = 1'b0;
    next_s.tick = 1'b0;
    wr_img = 16'h0000;
    // bus address and data channels, taken in either order
    if (i_awvalid && !s.awv) begin
      next_s.awv = 1'b1;
      next_s.aw_idx = i_awaddr[7:2];
    end
    if (i_wvalid && !s.wv) begin
      next_s.wv = 1'b1;
      next_s.wdata = i_wdata;
      next_s.wstrb = i_wstrb;
    end
    if (s.bvalid && i_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && i_rready) begin
      next_s.rvalid = 1'b0;
    end
    // read answer one cycle after the address is taken
    if (i_arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = rtc_ctl_pkg::RESP_OK;
      case (i_araddr[7:2])
        rtc_ctl_pkg::IDX_CTRL:   next_s.rdata = {16'h0000, ctrl_img};
        rtc_ctl_pkg::IDX_RDREQ:  next_s.rdata = {16'h0000, rdreq_img};
        rtc_ctl_pkg::IDX_EVENT_OUTPUT_CONTROL: next_s.rdata = {16'h0000, ev_img};
        rtc_ctl_pkg::IDX_STATUS: next_s.rdata = {24'h000000, s.busy, 7'h00};
        rtc_ctl_pkg::IDX_COUNT:  next_s.rdata = s.copy;
        default: begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = rtc_ctl_pkg::RESP_ERR;
        end
      endcase
    end

    // prescaler: counter tick every two-to-the-code source cycles
    if (s.run) begin
      next_s.div = s.div + 10'h001;
      next_s.tick = (s.div & div_mask) == div_mask;
    end else begin
      next_s.div = 10'h000;
    end

    // synchronised operation: request, fixed crossing delay, acknowledge
    if (s.op != rtc_ctl_pkg::OP_IDLE) begin
      if (s.req) begin
        next_s.req = 1'b0;
        next_s.dly = rtc_ctl_pkg::SYNC_CYC;
      end else if (s.dly != 3'h0) begin
        next_s.dly = s.dly - 3'h1;
      end else begin
        next_s.op = rtc_ctl_pkg::OP_IDLE;
        next_s.busy = 1'b0;
        case (s.op)
          rtc_ctl_pkg::OP_EN: next_s.run = s.en;
          rtc_ctl_pkg::OP_READ: next_s.copy = i_count_value;
          rtc_ctl_pkg::OP_RST: begin
            next_s.srt = 1'b0;
            next_s.en = 1'b0;
            next_s.run = 1'b0;
            next_s.psc = 4'h0;
            next_s.zom = 1'b0;
            next_s.hfs = 1'b0;
            next_s.mode = rtc_ctl_pkg::MODE_WIDE;
            next_s.cont = 1'b0;
            next_s.trig = 1'b0;
            next_s.ev_ovf = 1'b0;
            next_s.ev_cmp = 1'b0;
            next_s.ev_per = 8'h00;
            next_s.copy = 32'h00000000;
          end
          default: next_s.busy = 1'b0;
        endcase
        if (s.op == rtc_ctl_pkg::OP_READ && !s.cont) begin
          next_s.trig = 1'b0;
        end
      end
    end else if (s.cont && s.trig && s.tick) begin
      // with continuous read on and its trigger set, every counter update seen while no synchronised operation is in flight starts a fresh copy
      next_s.op = rtc_ctl_pkg::OP_READ;
      next_s.req = 1'b1;
      next_s.busy = 1'b1;
    end

    // register write commit
    if (commit) begin
      next_s.awv = 1'b0;
      next_s.wv = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = rtc_ctl_pkg::RESP_OK;
      wr_img = 16'h0000;
      if (s.aw_idx != rtc_ctl_pkg::IDX_RDREQ) begin
        next_s.cont = 1'b0;
      end
      case (s.aw_idx)
        rtc_ctl_pkg::IDX_CTRL: begin
          wr_img = merge16(ctrl_img & ~16'h0001, s.wdata[15:0], s.wstrb[1:0]);
          if (wr_img[rtc_ctl_pkg::CTRL_SRT]) begin
            // soft reset wins and the rest of the write is dropped
            next_s.srt = 1'b1;
            next_s.busy = 1'b1;
            next_s.op = rtc_ctl_pkg::OP_RST;
            next_s.req = 1'b1;
          end else begin
            if (!s.en) begin
              next_s.psc = wr_img[rtc_ctl_pkg::CTRL_PSC +: 4];
              next_s.mode = rtc_ctl_pkg::mode_t'(wr_img[rtc_ctl_pkg::CTRL_MODE +: 2]);
              next_s.zom = wr_img[rtc_ctl_pkg::CTRL_ZOM];
              next_s.hfs = wr_img[rtc_ctl_pkg::CTRL_HFS];
            end
            if (wr_img[rtc_ctl_pkg::CTRL_EN] != s.en || s.wstrb[0]) begin
              next_s.en = wr_img[rtc_ctl_pkg::CTRL_EN];
              next_s.busy = 1'b1;
              next_s.op = rtc_ctl_pkg::OP_EN;
              next_s.req = 1'b1;
            end
          end
        end
        rtc_ctl_pkg::IDX_RDREQ: begin
          wr_img = merge16(rdreq_img, s.wdata[15:0], s.wstrb[1:0]);
          if (s.wstrb[1]) begin
            next_s.cont = wr_img[rtc_ctl_pkg::RDREQ_CONT];
            if (wr_img[rtc_ctl_pkg::RDREQ_TRIG]) begin
              next_s.trig = 1'b1;
              next_s.busy = 1'b1;
              next_s.op = rtc_ctl_pkg::OP_READ;
              next_s.req = 1'b1;
            end
          end
        end
        rtc_ctl_pkg::IDX_EVENT_OUTPUT_CONTROL: begin
          wr_img = merge16(ev_img, s.wdata[15:0], s.wstrb[1:0]);
          if (!s.en) begin
            next_s.ev_ovf = wr_img[rtc_ctl_pkg::EV_OVF];
            next_s.ev_cmp = wr_img[rtc_ctl_pkg::EV_CMP];
            next_s.ev_per = wr_img[7:0];
          end
        end
        rtc_ctl_pkg::IDX_COUNT: begin
          next_s.load = 1'b1;
          next_s.load_data = s.wdata;
        end
        rtc_ctl_pkg::IDX_STATUS: next_s.bresp = rtc_ctl_pkg::RESP_OK;
        default: next_s.bresp = rtc_ctl_pkg::RESP_ERR;
      endcase
    end

    // event outputs, each gated by its own enable
    next_s.ev.overflow = s.run && s.ev_ovf && i_events.overflow;
    next_s.ev.compare0 = s.run && s.ev_cmp && i_events.compare0;
    next_s.ev.periodic = s.run ? (s.ev_per & i_events.periodic) : 8'h00;
    // clearing on match has no meaning in the half counter mode
    next_s.zero = s.run && s.zom && s.mode != rtc_ctl_pkg::MODE_HALF
                  && i_events.compare0;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_awready = !s.awv;
  assign o_wready  = !s.wv;
  assign o_bvalid  = s.bvalid;
  assign o_bresp   = s.bresp;
  assign o_arready = !s.rvalid;
  assign o_rvalid  = s.rvalid;
  assign o_rdata   = s.rdata;
  assign o_rresp   = s.rresp;
  assign o_counter_tick = s.tick;
  assign o_counter_run  = s.run;
  assign o_mode = s.mode;
  assign o_hour_format_select = s.hfs;
  assign o_counter_zero = s.zero;
  assign o_count_load = s.load;
  assign o_count_load_data = s.load_data;
  assign o_events = s.ev;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence ctrl_write;
    commit && s.aw_idx == rtc_ctl_pkg::IDX_CTRL;
  endsequence
  sequence srt_write;
    ctrl_write ##0 next_s.srt && !s.srt;
  endsequence

  a_enable_readback: assert property (
    ctrl_write and (s.wstrb[0] && !next_s.srt)
    |=> s.en == $past(s.wdata[rtc_ctl_pkg::CTRL_EN]))
    else $error("enable not read back at once");
  a_busy_on_write: assert property (ctrl_write and (s.wstrb[0]) |=> s.busy)
    else $error("busy not set by control write");
  a_busy_bounded: assert property ($rose(s.busy) |-> ##[1:12] !s.busy)
    else $error("busy never clears");
  a_reset_ends: assert property (srt_write |=> s.srt ##[1:12] (!s.srt && !s.busy && !s.en))
    else $error("soft reset did not complete");
  a_reset_discard: assert property (srt_write |=> $stable(s.psc) && $stable(s.mode))
    else $error("soft reset write changed fields");
  a_protect_fields: assert property (
    s.en |=> $stable(s.zom) && $stable(s.hfs) || $past(s.op) == rtc_ctl_pkg::OP_RST)
    else $error("protected field changed while enabled");
  a_overflow_gate: assert property (o_events.overflow |-> $past(s.ev_ovf))
    else $error("overflow event while disabled");
  a_compare_gate: assert property (o_events.compare0 |-> $past(s.ev_cmp))
    else $error("compare event while disabled");
  a_periodic_gate: assert property ((o_events.periodic & ~$past(s.ev_per)) == 8'h00)
    else $error("periodic event not gated");
  a_tick_div1: assert property (s.run && $past(s.run) && psc_eff == 4'h0 |=> o_counter_tick)
    else $error("divide by one missed a tick");
  a_cont_clear: assert property (commit && s.aw_idx == rtc_ctl_pkg::IDX_EVENT_OUTPUT_CONTROL |=> !s.cont)
    else $error("continuous read survived a write");
  a_zero_mode: assert property (o_counter_zero |-> $past(s.mode) != rtc_ctl_pkg::MODE_HALF)
    else $error("clear on match in half mode");

  // last cycle of a synchronised operation, with no write landing on top of it
  sequence op_done;
    !s.req && s.dly == 3'h0 && !commit;
  endsequence

  a_run_follows: assert property (s.op == rtc_ctl_pkg::OP_EN ##0 op_done
    |=> s.run == $past(s.en))
    else $error("run did not follow enable");
  a_reset_clears: assert property (s.op == rtc_ctl_pkg::OP_RST ##0 op_done
    |=> !s.en && !s.run && !s.srt && !s.busy && s.ev_per == 8'h00)
    else $error("soft reset left state behind");
  // the read trigger clears itself unless continuous read holds it
  a_trig_single: assert property (s.op == rtc_ctl_pkg::OP_READ && !s.cont ##0 op_done
    |=> !s.trig)
    else $error("read trigger did not clear");
  a_trig_held: assert property (s.op == rtc_ctl_pkg::OP_READ && s.cont ##0 op_done
    |=> s.trig)
    else $error("continuous read lost its trigger");
  a_read_start: assert property (
    commit && s.aw_idx == rtc_ctl_pkg::IDX_RDREQ && s.wstrb[1] && s.wdata[15] |=> s.busy && s.trig)
    else $error("read request did not start a copy");
  a_cont_any: assert property (commit && s.aw_idx != rtc_ctl_pkg::IDX_RDREQ |=> !s.cont)
    else $error("continuous read kept after a write");
  a_count_stall: assert property (
    s.awv && s.wv && !s.bvalid && s.aw_idx == rtc_ctl_pkg::IDX_COUNT |-> ##[1:12] s.bvalid)
    else $error("count write stalled too long");
  a_tick_running: assert property (o_counter_tick |-> $past(s.run))
    else $error("tick while stopped");
  a_reset_pending: assert property (s.op == rtc_ctl_pkg::OP_RST |-> s.srt && s.busy)
    else $error("soft reset not shown as pending");
  a_high_lane_only: assert property (
    ctrl_write and (!s.wstrb[0] && !s.srt) |=> !s.srt)
    else $error("idle byte lane started a reset");
endmodule : rtc_ctl

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  logic               i_clk = 1'b0;
  logic               i_reset = 1'b1;
  logic               i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic               i_arvalid = 1'b0, i_rready = 1'b0;
  logic [7:0]         i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0]        i_wdata = 32'h0, i_count_value = 32'h0;
  logic [3:0]         i_wstrb = 4'h0;
  rtc_ctl_pkg::evt_t  i_events = '0;
  logic               o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic               o_counter_tick, o_counter_run, o_hour_format_select;
  logic               o_counter_zero, o_count_load;
  logic [1:0]         o_bresp, o_rresp, rs;
  logic [31:0]        o_rdata, o_count_load_data, rv, ld;
  rtc_ctl_pkg::mode_t o_mode;
  rtc_ctl_pkg::evt_t  o_events;
  int                 num_errors = 0, checked = 0, cyc = 0, zseen = 0;
  int                 m_ctrl = 0, m_ev = 0, m_cont = 0, m_run = 0;

  rtc_ctl dut_u (
    .i_clk(i_clk), .i_reset(i_reset), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .i_count_value(i_count_value), .i_events(i_events), .o_counter_tick(o_counter_tick),
    .o_counter_run(o_counter_run), .o_mode(o_mode),
    .o_hour_format_select(o_hour_format_select), .o_counter_zero(o_counter_zero),
    .o_count_load(o_count_load), .o_count_load_data(o_count_load_data),
    .o_events(o_events)
  );

  always #2.5 i_clk = ~i_clk;

  task automatic close_out();
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // hang guard: the whole sequence needs only a few hundred cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end

  // pulses are caught at the falling edge, where registered outputs have settled
  always @(negedge i_clk) begin
    if (o_counter_zero === 1'b1) zseen++;
    if (o_count_load === 1'b1) ld = o_count_load_data;
  end

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  // register model: protected fields only move while the enable bit is clear
  function automatic void mwr(logic [7:0] a, logic [31:0] d, logic [3:0] s);
    int bm;
    int pm;
    bm = (s[0] ? 'hff : 0) | (s[1] ? 'hff00 : 0);
    m_cont = 0;
    if (a == 8'h00 && s[0] && d[0]) begin
      m_ctrl = m_ctrl | 1;
      m_ev = 0;
      m_run = 0;
    end else if (a == 8'h00) begin
      pm = m_ctrl[1] ? 'h2 : 'hfce;
      m_ctrl = (m_ctrl & ~(pm & bm)) | (d & pm & bm);
    end else if (a == 8'h10 && !m_ctrl[1]) m_ev = (m_ev & ~('h81ff & bm)) | (d & 'h81ff & bm);
    else if (a == 8'h08 && s[1]) m_cont = d[14];
  endfunction : mwr

  function automatic logic [9:0] gate(logic [9:0] v);
    return m_run ? v & {m_ev[15], m_ev[8], m_ev[7:0]} : 10'h000;
  endfunction : gate

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w, ta, tw, b;
    @(posedge i_clk);
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    i_wstrb <= s;
    i_bready <= 1'b1;
    while (aw | w) begin
      @(negedge i_clk);
      ta = aw & o_awready;
      tw = w & o_wready;
      @(posedge i_clk);
      if (ta) i_awvalid <= 1'b0;
      if (tw) i_wvalid <= 1'b0;
      aw = aw & ~ta;
      w = w & ~tw;
    end
    while (!b) begin
      @(negedge i_clk);
      b = o_bvalid;
      rs = o_bresp;
      @(posedge i_clk);
    end
    i_bready <= 1'b0;
    mwr(a, d, s);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ar, r, ta;
    @(posedge i_clk);
    ar = 1'b1;
    r = 1'b0;
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    while (!r) begin
      @(negedge i_clk);
      ta = ar & o_arready;
      r = o_rvalid;
      rv = o_rdata;
      rs = o_rresp;
      @(posedge i_clk);
      if (ta) i_arvalid <= 1'b0;
      ar = ar & ~ta;
    end
    i_rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("register %h", a), rv, e);
  endtask : rchk

  task automatic wait_idle();
    do rd(8'h28); while (rv[7] !== 1'b0);
  endtask : wait_idle

  task automatic tick_gap(input int p);
    int n;
    n = 0;
    @(negedge i_clk);
    while (o_counter_tick !== 1'b1) @(negedge i_clk);
    do begin
      @(negedge i_clk);
      n++;
    end while (o_counter_tick !== 1'b1 && n < 2000);
    chk("tick spacing", n, 1 << p);
  endtask : tick_gap

  // configure while disabled, then enable and wait for the handshake
  task automatic setup(input logic [31:0] c, input logic [31:0] e);
    wr(8'h00, c, 4'h3);
    wr(8'h10, e, 4'h3);
    chk("mode out", 32'(o_mode), c[3:2]);
    chk("hour format", 32'(o_hour_format_select), c[6]);
    wait_idle();
    wr(8'h00, c | 32'h2, 4'h3);
    rd(8'h28);
    chk("busy after enable", 32'(rv[7]), 1);
    rchk(8'h00, m_ctrl);
    wait_idle();
    m_run = 1;
    chk("run", 32'(o_counter_run), 1);
  endtask : setup

  // random event pulses; outputs follow one cycle later through the enables
  task automatic ev_phase(input int zon);
    logic [31:0] nv, pv;
    int zexp;
    pv = 0;
    zexp = 0;
    zseen = 0;
    repeat (40) begin
      nv = $urandom;
      @(posedge i_clk);
      i_events <= rtc_ctl_pkg::evt_t'(nv[9:0]);
      @(negedge i_clk);
      chk("events", 32'(o_events), 32'(gate(pv[9:0])));
      pv = nv;
      zexp += zon & nv[8];
    end
    @(posedge i_clk);
    i_events <= '0;
    repeat (3) @(posedge i_clk);
    chk("zero pulses", zseen, zexp);
  endtask : ev_phase

  initial begin
    logic [31:0] v;
    void'($urandom(49087));
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    rchk(8'h00, 32'h0);
    rchk(8'h08, 32'h10);
    rchk(8'h10, 32'h0);
    rd(8'h3c);
    chk("unmapped read resp", rs, 2);
    wr(8'h3c, 32'h1, 4'h1);
    chk("unmapped write resp", rs, 2);
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, k << 2, 4'h1);
      chk("mode out", 32'(o_mode), k);
      wait_idle();
    end
    // high byte only: the soft reset bit in the idle low lane must not act
    wr(8'h00, 32'h0301, 4'h2);
    rchk(8'h00, m_ctrl);
    setup(32'h03c8, 32'h8000 | ($urandom & 32'hff));
    tick_gap(3);
    wr(8'h00, 32'h0006, 4'h3);
    wait_idle();
    rchk(8'h00, m_ctrl);
    chk("hour format kept", 32'(o_hour_format_select), 1);
    wr(8'h10, 32'h0, 4'h3);
    rchk(8'h10, m_ev);
    ev_phase(1);
    v = $urandom;
    @(posedge i_clk);
    i_count_value <= v;
    wr(8'h08, 32'h8000, 4'h3);
    rd(8'h28);
    chk("busy after read request", 32'(rv[7]), 1);
    wait_idle();
    rchk(8'h40, v);
    wr(8'h08, 32'h4000, 4'h3);
    wr(8'h08, 32'hc000, 4'h3);
    rchk(8'h08, 32'h4010);
    v = $urandom;
    @(posedge i_clk);
    i_count_value <= v;
    repeat (40) @(posedge i_clk);
    rchk(8'h40, v);
    v = $urandom;
    wr(8'h40, v, 4'hf);
    chk("load data", ld, v);
    rchk(8'h08, 32'h10);
    wait_idle();
    // soft reset carrying other fields: those fields are dropped
    wr(8'h00, 32'h0a0f, 4'h3);
    rchk(8'h00, m_ctrl);
    wait_idle();
    m_ctrl = 0;
    rchk(8'h00, 32'h0);
    rchk(8'h10, 32'h0);
    chk("run after reset", 32'(o_counter_run), 0);
    setup(32'h0184, 32'h0100 | ($urandom & 32'hff));
    tick_gap(1);
    ev_phase(0);
    close_out();
  end
endmodule : tb
